/* pcie_port_cfg_pkg.sv */
// Constants and carrier types for the root port configuration and turn-off control block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pcie_port_cfg_pkg;

	//------------------------------------------------------------------------------
	// Register offsets
	//------------------------------------------------------------------------------
	localparam logic [7:0] ACK_STATUS_OFS  = 8'h00_A0;
	localparam logic [7:0] LANE_CONFIG_OFS = 8'h00_B0;
	localparam logic [7:0] PM_CONTROL_OFS  = 8'h00_F0;
	localparam logic [7:0] PRESENCE_OFS    = 8'h00_F1;

	//------------------------------------------------------------------------------
	// Field positions and port count
	//------------------------------------------------------------------------------
	localparam int LANE_SEL_BIT   = 7;
	localparam int RP1_WIDTH_BIT  = 3;
	localparam int TRIGGER_BIT    = 7;
	localparam int NUM_PORTS      = 4;

	//------------------------------------------------------------------------------
	// Reset values and the absent-port read value
	//------------------------------------------------------------------------------
	localparam logic       RP1_WIDTH_RST  = 1'b1;
	localparam logic [7:0] PM_CONTROL_RST = 8'h00_02;
	localparam logic [7:0] PRESENCE_RST   = 8'h00_0F;
	localparam logic [3:0] ACK_STATUS_RST = 4'h0_0;
	localparam logic [31:0] ABSENT_READ   = 32'hFFFF_FFFF;

	//------------------------------------------------------------------------------
	// Carrier types
	//------------------------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cfg_req_s;

	typedef struct packed {
		logic       rvalid;
		logic [7:0] rdata;
	} cfg_rsp_s;

	typedef struct packed {
		logic        valid;
		logic [1:0]  func;
		logic [31:0] data;
	} port_rd_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} port_rd_rsp_s;

	typedef struct packed {
		logic display_lanes;
		logic rp1_two_lanes;
		logic rp2_enable;
	} lane_route_s;

endpackage : pcie_port_cfg_pkg

/* ack_status_bit.sv */
// One sticky acknowledge status bit with write-one-to-clear
module ack_status_bit #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);

	typedef struct packed {
		logic flag;
	} bit_state_s;

	bit_state_s st_q;
	bit_state_s st_d;

	//------------------------------------------------------------------------------
	// Next state
	//------------------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		if (set)
			st_d.flag = 1'b1;
		else if (clr)
			st_d.flag = 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			st_q.flag <= RST_VAL;
		else
			st_q <= st_d;
	end

	assign q = st_q.flag;

endmodule : ack_status_bit

/* pcie_port_cfg.sv */
// Root port lane routing, port presence filter and turn-off broadcast control
module pcie_port_cfg (
	input  wire logic                            mclk,
	input  wire logic                            resetn,
	input  wire logic                            power_stop_strap_ball,
	input  wire pcie_port_cfg_pkg::cfg_req_s     cfg_req,
	output pcie_port_cfg_pkg::cfg_rsp_s          cfg_rsp,
	input  wire pcie_port_cfg_pkg::port_rd_s     port_rd,
	output pcie_port_cfg_pkg::port_rd_rsp_s      port_rd_rsp,
	input  wire logic [3:0]                      pme_to_ack,
	output logic                                 turn_off_send,
	output pcie_port_cfg_pkg::lane_route_s       lane_route,
	output logic [3:0]                           port_present
);
	import pcie_port_cfg_pkg::*;

	typedef struct packed {
		logic         lane_sel;
		logic         rp1_width;
		logic [7:0]   pm_ctrl;
		logic [7:0]   presence;
		cfg_rsp_s     rsp;
		port_rd_rsp_s prsp;
		logic         turn_off;
		lane_route_s  route;
		logic [3:0]   present;
	} cfg_state_s;

	cfg_state_s st_q;
	cfg_state_s st_d;

	logic [3:0] ack_q;
	logic [3:0] ack_set;
	logic [3:0] ack_clr;
	logic       wr_en;
	logic       rd_en;
	logic       hit_ack;
	logic       hit_pm;
	logic       armed;
	logic       func_absent;
	logic       trig_fresh;

	//------------------------------------------------------------------------------
	// Request decode
	//------------------------------------------------------------------------------
	assign wr_en = cfg_req.valid & cfg_req.write;
	assign rd_en = cfg_req.valid & ~cfg_req.write;

	always_comb
	begin
		hit_ack = (cfg_req.addr == ACK_STATUS_OFS);
		hit_pm = (cfg_req.addr == PM_CONTROL_OFS);
		// Stored trigger bit marks the window in which acks count
		armed = st_q.pm_ctrl[TRIGGER_BIT];
		func_absent = !st_q.presence[port_rd.func];
	end

	//------------------------------------------------------------------------------
	// Turn-off trigger
	//------------------------------------------------------------------------------
	// Fresh rising write
	// Compared with the stored bit, so rewriting a one stays silent
	assign trig_fresh = wr_en && hit_pm
		&& cfg_req.wdata[TRIGGER_BIT]
		&& !armed;

	//------------------------------------------------------------------------------
	// Acknowledge status bits
	//------------------------------------------------------------------------------
	always_comb
	begin
		ack_set = pme_to_ack & {NUM_PORTS{armed}};
		if (wr_en && hit_ack)
			ack_clr = cfg_req.wdata[3:0];
		else
			ack_clr = 4'h0_0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++)
		begin : g_ack
			ack_status_bit #(
				.RST_VAL (ACK_STATUS_RST[gi])
			) u_ack (
				.mclk   (mclk),
				.resetn (resetn),
				.set    (ack_set[gi]),
				.clr    (ack_clr[gi]),
				.q      (ack_q[gi])
			);
		end
	endgenerate

	//------------------------------------------------------------------------------
	// Next state
	//------------------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		st_d.rsp.rvalid = 1'b0;
		st_d.rsp.rdata = 8'h00_00;
		st_d.prsp.valid = 1'b0;
		// Filtered data holds between answers
		st_d.prsp.data = st_q.prsp.data;

		// Register writes
		if (wr_en)
		begin
			case (cfg_req.addr)
				LANE_CONFIG_OFS:
				begin
					st_d.lane_sel = cfg_req.wdata[LANE_SEL_BIT];
					st_d.rp1_width = cfg_req.wdata[RP1_WIDTH_BIT];
				end
				PM_CONTROL_OFS:
				begin
					st_d.pm_ctrl = cfg_req.wdata;
				end
				PRESENCE_OFS:
				begin
					st_d.presence = cfg_req.wdata;
				end
				// Other offsets are the write-one-to-clear ack status (cleared above) or unmapped
				default:
				begin
					st_d.presence = st_q.presence;
				end
			endcase
		end

		// Register reads
		if (rd_en)
		begin
			st_d.rsp.rvalid = 1'b1;
			case (cfg_req.addr)
				ACK_STATUS_OFS:
				begin
					st_d.rsp.rdata = {4'h0_0, ack_q};
				end
				LANE_CONFIG_OFS:
				begin
					st_d.rsp.rdata = {st_q.lane_sel, 3'b000, st_q.rp1_width, 3'b000};
				end
				PM_CONTROL_OFS:
				begin
					st_d.rsp.rdata = st_q.pm_ctrl;
				end
				PRESENCE_OFS:
				begin
					st_d.rsp.rdata = st_q.presence;
				end
				// Unmapped offsets answer zero
				default:
				begin
					st_d.rsp.rdata = 8'h00_00;
				end
			endcase
		end

		st_d.turn_off = trig_fresh;

		// Root port function reads
		if (port_rd.valid)
		begin
			st_d.prsp.valid = 1'b1;
			if (func_absent)
				st_d.prsp.data = ABSENT_READ;
			else
				st_d.prsp.data = port_rd.data;
		end

		// Taken from the next state so routing lands with the write
		// Low lane routing
		st_d.route.display_lanes = st_d.lane_sel;
		st_d.route.rp1_two_lanes = ~st_d.rp1_width;
		st_d.route.rp2_enable = st_d.rp1_width;
		st_d.present = st_d.presence[3:0];
	end

	//------------------------------------------------------------------------------
	// State register
	//------------------------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			// Strap follows the pin on every reset edge; the last sample stays
			// Strap sampled in reset
			st_q.lane_sel <= power_stop_strap_ball;
			st_q.rp1_width <= RP1_WIDTH_RST;
			st_q.pm_ctrl <= PM_CONTROL_RST;
			st_q.presence <= PRESENCE_RST;
			st_q.rsp <= '0;
			st_q.prsp <= '0;
			st_q.turn_off <= 1'b0;
			st_q.route.display_lanes <= power_stop_strap_ball;
			st_q.route.rp1_two_lanes <= ~RP1_WIDTH_RST;
			st_q.route.rp2_enable <= RP1_WIDTH_RST;
			st_q.present <= PRESENCE_RST[3:0];
		end
		else
		begin
			st_q <= st_d;
		end
	end

	//------------------------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------------------------
	// Every output is a register field
	assign cfg_rsp = st_q.rsp;
	assign port_rd_rsp = st_q.prsp;
	assign turn_off_send = st_q.turn_off;
	assign lane_route = st_q.route;
	assign port_present = st_q.present;

endmodule : pcie_port_cfg

/* pcie_port_cfg_assertions.sv */
// Port-level checks for the root port configuration block
module pcie_port_cfg_checker (
	input wire logic                            mclk,
	input wire logic                            resetn,
	input wire logic                            power_stop_strap_ball,
	input wire pcie_port_cfg_pkg::cfg_req_s     cfg_req,
	input wire pcie_port_cfg_pkg::cfg_rsp_s     cfg_rsp,
	input wire pcie_port_cfg_pkg::port_rd_s     port_rd,
	input wire pcie_port_cfg_pkg::port_rd_rsp_s port_rd_rsp,
	input wire logic [3:0]                      pme_to_ack,
	input wire logic                            turn_off_send,
	input wire pcie_port_cfg_pkg::lane_route_s  lane_route,
	input wire logic [3:0]                      port_present
);
	import pcie_port_cfg_pkg::*;
	logic trig_q;
	wire  f0_wr = cfg_req.valid && cfg_req.write && cfg_req.addr == PM_CONTROL_OFS;
	wire  b0_wr = cfg_req.valid && cfg_req.write && cfg_req.addr == LANE_CONFIG_OFS;
	wire  b0_rd = cfg_req.valid && !cfg_req.write && cfg_req.addr == LANE_CONFIG_OFS;
	wire  f1_wr = cfg_req.valid && cfg_req.write && cfg_req.addr == PRESENCE_OFS;
	// Mirror of the stored trigger bit
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			trig_q <= 1'b0;
		else if (f0_wr)
			trig_q <= cfg_req.wdata[TRIGGER_BIT];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_trig_wr;
		f0_wr && cfg_req.wdata[TRIGGER_BIT] && !trig_q;
	endsequence
	a_turn_off_fire: assert property (s_trig_wr |=> turn_off_send)
		else $error("turn-off broadcast missing");
	a_turn_off_fresh: assert property (turn_off_send |-> $past(f0_wr && cfg_req.wdata[7] && !trig_q))
		else $error("turn-off broadcast without fresh write");
	a_lane_select: assert property (b0_wr |=> lane_route.display_lanes == $past(cfg_req.wdata[7]))
		else $error("lane select not applied");
	a_width_route: assert property (b0_wr |=> lane_route.rp1_two_lanes == !$past(cfg_req.wdata[3])
		&& lane_route.rp2_enable == $past(cfg_req.wdata[3]))
		else $error("port one width not applied");
	a_strap_load: assert property ($rose(resetn) |-> lane_route.display_lanes == $past(power_stop_strap_ball))
		else $error("strap not loaded");
	a_absent_ones: assert property (port_rd.valid && !port_present[port_rd.func]
		|=> port_rd_rsp.valid && port_rd_rsp.data == ABSENT_READ)
		else $error("absent port read not all ones");
	a_present_data: assert property (port_rd.valid && port_present[port_rd.func]
		|=> port_rd_rsp.valid && port_rd_rsp.data == $past(port_rd.data))
		else $error("present port read data wrong");
	a_reserved_zero: assert property (b0_rd |=> cfg_rsp.rvalid && (cfg_rsp.rdata & 8'h77) == 8'h00)
		else $error("reserved lane bits not zero");
	a_turn_off_pulse: assert property (turn_off_send |=> !turn_off_send)
		else $error("turn-off broadcast longer than one cycle");
	a_presence_apply: assert property (f1_wr |=> port_present == $past(cfg_req.wdata[3:0]))
		else $error("presence bits not applied");
endmodule : pcie_port_cfg_checker

bind pcie_port_cfg pcie_port_cfg_checker i_pcie_port_cfg_checker (.mclk, .resetn, .power_stop_strap_ball,
	.cfg_req, .cfg_rsp, .port_rd, .port_rd_rsp, .pme_to_ack, .turn_off_send, .lane_route, .port_present);

/* pcie_endpoint_model.sv */
// Endpoints answering a turn-off broadcast with per-port acknowledges
module pcie_endpoint_model (
	input  wire logic       mclk,
	input  wire logic       turn_off_send,
	input  wire logic [3:0] mute,
	output logic [3:0]      ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] dly = '0;
	initial ack = 4'h0;
	// Port i answers 2+2i cycles after the broadcast; a muted port stays silent
	always @(posedge mclk)
	begin
		#1;
		dly = {dly[8:0], turn_off_send};
		ack = {dly[8], dly[6], dly[4], dly[2]} & ~mute;
	end
endmodule : pcie_endpoint_model

/* tb.sv */
// Self-checking bench for the root port configuration block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pcie_port_cfg_pkg::*;
	logic         mclk = 1'b0;
	logic         resetn = 1'b0;
	logic         strap = 1'b1;
	cfg_req_s     cfg_req = '0;
	cfg_rsp_s     cfg_rsp;
	port_rd_s     port_rd = '0;
	port_rd_rsp_s port_rd_rsp;
	logic [3:0]   ack;
	logic [3:0]   mute = 4'h0;
	logic         turn_off_send;
	lane_route_s  lane_route;
	logic [3:0]   port_present;
	int           failures = 0;
	int           compares = 0;
	int           cycles = 0;
	always #4 mclk = ~mclk;
	pcie_port_cfg i_pcie_port_cfg (.mclk(mclk), .resetn(resetn), .power_stop_strap_ball(strap),
		.cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .port_rd(port_rd), .port_rd_rsp(port_rd_rsp), .pme_to_ack(ack),
		.turn_off_send(turn_off_send), .lane_route(lane_route), .port_present(port_present));
	pcie_endpoint_model i_pcie_endpoint_model (.mclk(mclk), .turn_off_send(turn_off_send), .mute(mute), .ack(ack));
	task end_sim;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			failures++;
			end_sim();
		end
	end
	task chk(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp)
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			failures++;
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		cfg_req = '{1'b1, 1'b1, a, d};
		cyc(1);
		cfg_req.valid = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		cyc(1);
		cfg_req = '{1'b1, 1'b0, a, 8'h00};
		cyc(1);
		cfg_req.valid = 1'b0;
		chk({cfg_rsp.rvalid, cfg_rsp.rdata}, {1'b1, e});
	endtask : rd
	task prd(input logic [1:0] f, input logic [31:0] d, input logic [31:0] e);
		cyc(1);
		port_rd = '{1'b1, f, d};
		cyc(1);
		port_rd.valid = 1'b0;
		chk({port_rd_rsp.valid, port_rd_rsp.data}, {1'b1, e});
	endtask : prd
	task do_reset(input logic s);
		strap = s;
		resetn = 1'b0;
		cyc(10);
		resetn = 1'b1;
	endtask : do_reset
	task t_defaults;
		chk(lane_route, {strap, 2'b01});
		chk(port_present, 4'hF);
		rd(LANE_CONFIG_OFS, {strap, 7'h08});
		rd(PM_CONTROL_OFS, PM_CONTROL_RST);
		rd(PRESENCE_OFS, 8'h0F);
		rd(ACK_STATUS_OFS, 8'h00);
		rd(8'hC0, 8'h00);
	endtask : t_defaults
	task t_lanes;
		wr(LANE_CONFIG_OFS, 8'hFF);
		chk(lane_route, 3'b101);
		rd(LANE_CONFIG_OFS, 8'h88);
		wr(LANE_CONFIG_OFS, 8'h00);
		chk(lane_route, 3'b010);
		rd(LANE_CONFIG_OFS, 8'h00);
	endtask : t_lanes
	task t_turn_off;
		mute = 4'h4;
		wr(PM_CONTROL_OFS, 8'h80);
		chk(turn_off_send, 1'b1);
		cyc(10);
		rd(ACK_STATUS_OFS, 8'h0B);
		mute = 4'h0;
		wr(PM_CONTROL_OFS, 8'h80);
		chk(turn_off_send, 1'b0);
		wr(PM_CONTROL_OFS, 8'h00);
		wr(PM_CONTROL_OFS, 8'h80);
		chk(turn_off_send, 1'b1);
		cyc(10);
		rd(ACK_STATUS_OFS, 8'h0F);
		wr(ACK_STATUS_OFS, 8'h03);
		rd(ACK_STATUS_OFS, 8'h0C);
	endtask : t_turn_off
	task t_presence;
		wr(PRESENCE_OFS, 8'h05);
		chk(port_present, 4'h5);
		for (int f = 0; f < 4; f++)
			prd(f[1:0], 32'h1234_5670 + f, f[0] ? ABSENT_READ : 32'h1234_5670 + f);
	endtask : t_presence
	task t_strap_low;
		wr(LANE_CONFIG_OFS, 8'h80);
		chk(lane_route.display_lanes, 1'b1);
	endtask : t_strap_low
	initial
	begin
		do_reset(1'b1);
		t_defaults;
		t_lanes;
		t_turn_off;
		t_presence;
		do_reset(1'b0);
		t_defaults;
		t_strap_low;
		end_sim;
	end
endmodule : tb
